// ### pie_defines.svh
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH

// Register byte offsets (word aligned)
`define PIE_OFS_ENABLE    4'h0
`define PIE_OFS_GLOBAL    4'h4
`define PIE_OFS_STATUS    4'h8
`define PIE_OFS_MASK      4'hC

// Enable register layout
`define PIE_BIT_SCANNER   7
`define PIE_BIT_CHECKSUM  6
`define PIE_BIT_MEMTASK   5
`define PIE_BIT_OSC       4
`define PIE_BIT_RSVD      3
`define PIE_BIT_WGEN_C    2
`define PIE_BIT_WGEN_B    1
`define PIE_BIT_WGEN_A    0
`define PIE_ENABLE_MASK   8'hF7
`define PIE_ENABLE_RESET  8'h00
`define PIE_GLOBAL_RESET  1'h0
`define PIE_STATUS_RESET  8'h00
`define PIE_MASK_RESET    8'h00
`define PIE_VEC_RESET     8'h00
`define PIE_RDATA_RESET   32'h0000_0000
`define PIE_RDATA_IDLE    32'h0000_0000
`define PIE_NUM_SRC       8

`endif

// ### pie_pkg.sv
package pie_pkg;
    typedef logic [7:0] pie_byte_t;
endpackage : pie_pkg

// ### pie_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for the request lines arriving from other logic
module pie_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    initial begin
        if (WIDTH < 1) $error("pie_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : pie_sync

// ### pie_irq_enable.sv
`timescale 1ns/10ps
`include "pie_defines.svh"

module pie_irq_enable #(
    parameter int NUM_SRC = `PIE_NUM_SRC
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Peripheral request flags, bit order as the enable register
    input  wire logic [7:0]  periph_req,
    // Gated request to the processor
    output logic             periph_irq,
    output logic [7:0]       periph_irq_vec,
    // Sticky-status interrupt
    output logic             irq
);
    pie_pkg::pie_byte_t peripheral_irq_enable_six_ff;
    logic               global_peripheral_irq_enable_ff;
    pie_pkg::pie_byte_t status_ff;
    pie_pkg::pie_byte_t mask_ff;
    pie_pkg::pie_byte_t req_sync;
    pie_pkg::pie_byte_t gated;
    pie_pkg::pie_byte_t gated_d_ff;
    logic               ack_ff;
    logic               wr_en;
    logic               rd_en;
    logic [31:0]        nxt_readdata;
    logic               scanner_irq_enable;
    logic               checksum_irq_enable;
    logic               memory_task_irq_enable;
    logic               oscillator_rollover_irq_enable;
    logic               waveform_gen_c_irq_enable;
    logic               waveform_gen_b_irq_enable;
    logic               waveform_gen_a_irq_enable;

    // The bit layout is fixed by the register, so only one source count can be served
    if (NUM_SRC != `PIE_NUM_SRC) begin : g_bad_num_src
        $error("pie_irq_enable: NUM_SRC must be 8");
    end

    function automatic logic sel(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction : sel

    pie_sync #(.WIDTH(8)) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (periph_req),
        .sync_out (req_sync)
    );

    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    // A write lands only at the edge where the master sees waitrequest low
    assign wr_en           = avs_write & ack_ff;
    assign rd_en           = avs_read & ~ack_ff;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) ack_ff <= 1'b0;
        else         ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            peripheral_irq_enable_six_ff <= `PIE_ENABLE_RESET;
        end else if (wr_en && avs_byteenable[0] && sel(avs_address, `PIE_OFS_ENABLE)) begin
            // Bit 3 is not stored so it always reads zero
            peripheral_irq_enable_six_ff <= avs_writedata[7:0] & `PIE_ENABLE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            global_peripheral_irq_enable_ff <= `PIE_GLOBAL_RESET;
        end else if (wr_en && avs_byteenable[0] && sel(avs_address, `PIE_OFS_GLOBAL)) begin
            global_peripheral_irq_enable_ff <= avs_writedata[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_ff <= `PIE_MASK_RESET;
        end else if (wr_en && avs_byteenable[0] && sel(avs_address, `PIE_OFS_MASK)) begin
            mask_ff <= avs_writedata[7:0];
        end
    end

    // Per-source enables under their own names
    assign scanner_irq_enable             = peripheral_irq_enable_six_ff[`PIE_BIT_SCANNER];
    assign checksum_irq_enable            = peripheral_irq_enable_six_ff[`PIE_BIT_CHECKSUM];
    assign memory_task_irq_enable         = peripheral_irq_enable_six_ff[`PIE_BIT_MEMTASK];
    assign oscillator_rollover_irq_enable = peripheral_irq_enable_six_ff[`PIE_BIT_OSC];
    assign waveform_gen_c_irq_enable      = peripheral_irq_enable_six_ff[`PIE_BIT_WGEN_C];
    assign waveform_gen_b_irq_enable      = peripheral_irq_enable_six_ff[`PIE_BIT_WGEN_B];
    assign waveform_gen_a_irq_enable      = peripheral_irq_enable_six_ff[`PIE_BIT_WGEN_A];

    // Per-source gating, then the global enable on periph_irq only
    assign gated[`PIE_BIT_SCANNER]  = req_sync[`PIE_BIT_SCANNER] & scanner_irq_enable;
    assign gated[`PIE_BIT_CHECKSUM] = req_sync[`PIE_BIT_CHECKSUM] & checksum_irq_enable;
    assign gated[`PIE_BIT_MEMTASK]  = req_sync[`PIE_BIT_MEMTASK] & memory_task_irq_enable;
    assign gated[`PIE_BIT_OSC]      = req_sync[`PIE_BIT_OSC] & oscillator_rollover_irq_enable;
    // No source behind the unimplemented bit
    assign gated[`PIE_BIT_RSVD]     = 1'b0;
    assign gated[`PIE_BIT_WGEN_C]   = req_sync[`PIE_BIT_WGEN_C] & waveform_gen_c_irq_enable;
    assign gated[`PIE_BIT_WGEN_B]   = req_sync[`PIE_BIT_WGEN_B] & waveform_gen_b_irq_enable;
    assign gated[`PIE_BIT_WGEN_A]   = req_sync[`PIE_BIT_WGEN_A] & waveform_gen_a_irq_enable;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            periph_irq_vec <= `PIE_VEC_RESET;
            periph_irq     <= 1'b0;
            gated_d_ff     <= `PIE_VEC_RESET;
        end else begin
            periph_irq_vec <= gated;
            periph_irq     <= global_peripheral_irq_enable_ff & (|gated);
            gated_d_ff     <= gated;
        end
    end

    // Rising edges of enabled requests latch; a read of status clears, new events win
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_ff <= `PIE_STATUS_RESET;
        end else if (rd_en && sel(avs_address, `PIE_OFS_STATUS)) begin
            status_ff <= gated & ~gated_d_ff;
        end else begin
            status_ff <= status_ff | (gated & ~gated_d_ff);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) irq <= 1'b0;
        else         irq <= |(status_ff & mask_ff);
    end

    always_comb begin
        nxt_readdata = `PIE_RDATA_IDLE;
        if (sel(avs_address, `PIE_OFS_ENABLE))      nxt_readdata[7:0] = peripheral_irq_enable_six_ff;
        else if (sel(avs_address, `PIE_OFS_GLOBAL)) nxt_readdata[0]   = global_peripheral_irq_enable_ff;
        else if (sel(avs_address, `PIE_OFS_STATUS)) nxt_readdata[7:0] = status_ff;
        else if (sel(avs_address, `PIE_OFS_MASK))   nxt_readdata[7:0] = mask_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst)    avs_readdata <= `PIE_RDATA_RESET;
        else if (rd_en) avs_readdata <= nxt_readdata;
    end
endmodule : pie_irq_enable

// ### pie_irq_enable_sva.sv
`timescale 1ns/10ps
module pie_irq_enable_chk (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic [7:0]  periph_req,
    input wire logic [7:0]  periph_irq_vec,
    input wire logic        periph_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    scan_gate_a: assert property (periph_irq_vec[7] |-> $past(periph_req[7], 3))
        else $error("scanner irq without request");
    crc_gate_a: assert property (periph_irq_vec[6] |-> $past(periph_req[6], 3))
        else $error("checksum irq without request");
    wgen_b_gate_a: assert property (periph_irq_vec[1] |-> $past(periph_req[1], 3))
        else $error("generator b irq without request");
    rst_clear_a: assert property ($fell(sys_rst) |-> periph_irq_vec == 8'h00)
        else $error("gated requests not clear after reset");
    one_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait state");
    global_gate_a: assert property (periph_irq |-> |periph_irq_vec)
        else $error("processor irq with no gated request");
    rsvd_zero_a: assert property (rd_done ##0 avs_address == 4'h0 |-> !avs_readdata[3])
        else $error("unimplemented enable bit reads one");
endmodule : pie_irq_enable_chk
bind pie_irq_enable pie_irq_enable_chk u_chk (.*);

// ### pie_irq_enable_tb.sv
`timescale 1ns/10ps
module pie_irq_enable_tb;
    logic        ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [7:0]  periph_req = 8'h00, periph_irq_vec, m;
    logic        avs_waitrequest, periph_irq, irq;
    int          errors = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    pie_irq_enable u_dut (.avs_byteenable(4'hF), .*);
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !w;
        avs_write <= w;
        do @(posedge ref_clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic results;
        if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Whole run is under two hundred cycles
    initial begin
        #100000;
        errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        bus(0, 4'h0, 8'h00); chk("enable", 0, rd);
        bus(1, 4'h0, 8'hFF); bus(0, 4'h0, 8'h00); chk("enable", 32'hF7, rd);
        bus(1, 4'h4, 8'h01);
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            periph_req <= m;
            repeat (4) @(posedge ref_clk);
            chk("vec", m & 8'hF7, periph_irq_vec);
            chk("pirq", i != 3, periph_irq);
            bus(1, 4'h0, ~m);
            @(posedge ref_clk);
            chk("vec", 0, periph_irq_vec);
            bus(1, 4'h0, 8'hFF);
        end
        bus(1, 4'h4, 8'h00);
        @(posedge ref_clk);
        chk("pirq", 0, periph_irq);
        chk("vec", 8'h80, periph_irq_vec);
        periph_req <= 8'h00;
        repeat (4) @(posedge ref_clk);
        bus(0, 4'h8, 8'h00); chk("status", 32'hF7, rd);
        periph_req <= 8'h80;
        repeat (5) @(posedge ref_clk);
        chk("irq", 0, irq);
        bus(1, 4'hC, 8'h80);
        @(posedge ref_clk);
        chk("irq", 1, irq);
        bus(0, 4'h8, 8'h00); chk("status", 32'h80, rd);
        @(posedge ref_clk);
        chk("irq", 0, irq);
        bus(0, 4'h2, 8'h00); chk("unmapped", 0, rd);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        bus(0, 4'h0, 8'h00); chk("enable", 0, rd);
        chk("vec", 0, periph_irq_vec);
        results();
    end
endmodule : pie_irq_enable_tb
